// >>> rtl/low_power_domain_pwm.sv
// Three-channel low-power pulse generator with its APB register file.
//
// How it works
// - Three independent channels, each routable to a pad.
// - Sixteen-bit high count sets high cycles.
// - Sixteen-bit low count sets low cycles.
// - Control bit 0 runs or stops counter.
// - Control bit 1 connects waveform to pad.
// - Control bit 2 selects single period mode.
// - Control bit 3 holds counter in reset.
// - Control bit 4 inverts the output level.
// - Reset controller bit 6 releases the block.
module low_power_domain_pwm
  import pulse_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pad side, one bit per channel.
  output logic [NUM_CH-1:0] o_pulse_level,
  output logic [NUM_CH-1:0] o_pulse_oe_n
);

  // Register map, as byte addresses; each register takes one aligned word.
  // The high count of channel 0 sits at 0x240 and its low count at 0x248.
  // Channel 1 uses 0x250 and 0x258, and channel 2 uses 0x260 and 0x268.
  // The channel controls sit at 0x290, 0x294 and 0x298.
  // The status word sits at 0x29C and is read only; writes to it are ignored.
  // The shared reset controller sits at 0x158 and the clock controller at 0x15C.
  // Addresses outside this map, or not word aligned, answer with an error.
  // Only the low bits of each word are implemented; the rest read as zero.

  // High-phase counts, one per channel.
  logic [CNT_W-1:0] high_count [NUM_CH];
  // Low-phase counts, one per channel.
  logic [CNT_W-1:0] low_count [NUM_CH];
  // Channel control bits; bits 7:5 are reserved and read zero.
  logic [CTL_W-1:0] control [NUM_CH];
  // Block reset release, taken from the shared reset controller.
  logic blk_release;
  // Block clock enable, taken from the shared clock controller.
  logic blk_clk_en;

  // Phase and raw wave from each sequencer.
  phase_e phase [NUM_CH];
  logic [NUM_CH-1:0] wave;
  // Hold request into each sequencer.
  logic [NUM_CH-1:0] hold;

  // Bus decode of the current request.
  logic [7:0] req_idx;
  logic req_hit;
  logic setup_cyc;
  logic access_cyc;
  logic wr_take;
  logic [31:0] rd_value;

  // Checks a byte address for word alignment and range, flagging misaligned or
  // out-of-range addresses as a miss.
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == '0);
  endfunction

  // Merges write data into a 16-bit register under the byte strobes.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    merge16[7:0] = s[0] ? d[7:0] : old[7:0];
    merge16[15:8] = s[1] ? d[15:8] : old[15:8];
  endfunction

  // Tells whether an index belongs to the register map.
  function automatic logic idx_mapped(input logic [7:0] i);
    case (i)
      IDX_HIGH0, IDX_LOW0, IDX_HIGH1, IDX_LOW1, IDX_HIGH2, IDX_LOW2,
      IDX_CTRL0, IDX_CTRL1, IDX_CTRL2, IDX_STATUS, IDX_RSTCTL,
      IDX_CLKCTL: begin
        idx_mapped = 1'b1;
      end
      default: begin
        idx_mapped = 1'b0;
      end
    endcase
  endfunction

  // The index sits in address bits 9:2.
  assign req_idx = i_paddr[9:2];
  assign req_hit = addr_ok(i_paddr) && idx_mapped(req_idx);

  // A setup cycle arms the answer for the following access cycle.
  assign setup_cyc = i_psel && !i_penable;
  // The access completes on the edge where our ready is high.
  assign access_cyc = i_psel && i_penable && o_pready;
  // Writes take effect only on that completing edge.
  assign wr_take = access_cyc && i_pwrite && req_hit;

  // Transfer timing, seen from the bus: the setup edge arms ready, read
  // data and error for the next cycle, so every transfer takes exactly one
  // access cycle and no wait states are ever inserted. The answer stands
  // for that one cycle only and is cleared afterwards, which keeps the
  // read data bus at zero between transfers.
  // Ready rises for exactly the first access cycle, giving one wait-free
  // access phase; the registered answer keeps o_prdata off a long
  // combinational path at the cost of one setup cycle of latency.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= setup_cyc;
    end
  end

  // Unmapped or misaligned addresses answer with an error.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= setup_cyc && !req_hit;
    end
  end

  // Read data is captured at setup and cleared afterwards.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
    end else if (setup_cyc && !i_pwrite && req_hit) begin
      o_prdata <= rd_value;
    end else begin
      o_prdata <= 32'h00000000;
    end
  end

  // Status word layout: bits 2:0 show which channels are in a high or low
  // phase, bits 5:3 show which channels have finished a single period, and
  // bits 8:6 mirror the pad levels. Reading it has no side effect, so
  // software may poll it as often as it likes.
  // Read multiplexer; narrow registers sit in the low bits.
  always_comb begin
    rd_value = 32'h00000000;
    case (req_idx)
      IDX_HIGH0: begin
        rd_value[CNT_W-1:0] = high_count[0];
      end
      IDX_LOW0: begin
        rd_value[CNT_W-1:0] = low_count[0];
      end
      IDX_HIGH1: begin
        rd_value[CNT_W-1:0] = high_count[1];
      end
      IDX_LOW1: begin
        rd_value[CNT_W-1:0] = low_count[1];
      end
      IDX_HIGH2: begin
        rd_value[CNT_W-1:0] = high_count[2];
      end
      IDX_LOW2: begin
        rd_value[CNT_W-1:0] = low_count[2];
      end
      IDX_CTRL0: begin
        rd_value[CTL_W-1:0] = control[0];
      end
      IDX_CTRL1: begin
        rd_value[CTL_W-1:0] = control[1];
      end
      IDX_CTRL2: begin
        rd_value[CTL_W-1:0] = control[2];
      end
      IDX_RSTCTL: begin
        rd_value[RST_PWM_BIT] = blk_release;
      end
      IDX_CLKCTL: begin
        rd_value[CLK_PWM_BIT] = blk_clk_en;
      end
      IDX_STATUS: begin
        // Live channel state, so software can see a single period end.
        for (int c = 0; c < NUM_CH; c++) begin
          rd_value[ST_RUN_LSB + c] = (phase[c] == PH_HIGH) ||
                                     (phase[c] == PH_LOW);
          rd_value[ST_DONE_LSB + c] = (phase[c] == PH_DONE);
          rd_value[ST_LVL_LSB + c] = o_pulse_level[c];
        end
      end
      default: begin
        rd_value = 32'h00000000;
      end
    endcase
  end

  // A count may be rewritten while its channel runs; the new value is used
  // from the next compare, with no shadow copy, which saves a register set
  // at the cost of one odd period around the change.
  // High-phase count registers.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        high_count[c] <= COUNT_RST;
      end
    end else if (wr_take) begin
      // Channel n lives at the base index plus four times n.
      for (int c = 0; c < NUM_CH; c++) begin
        if (req_idx == IDX_HIGH0 + 8'(4 * c)) begin
          high_count[c] <= merge16(high_count[c], i_pwdata, i_pstrb);
        end
      end
    end
  end

  // Low-phase count registers.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        low_count[c] <= COUNT_RST;
      end
    end else if (wr_take) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (req_idx == IDX_LOW0 + 8'(4 * c)) begin
          low_count[c] <= merge16(low_count[c], i_pwdata, i_pstrb);
        end
      end
    end
  end

  // Bits 7:5 of a control write are dropped, since the register only
  // holds the five defined bits.
  // Channel control registers; only byte lane 0 carries them.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        control[c] <= CTRL_RST;
      end
    end else if (wr_take && i_pstrb[0]) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (req_idx == IDX_CTRL0 + 8'(c)) begin
          control[c] <= i_pwdata[CTL_W-1:0];
        end
      end
    end
  end

  // These two bits stand for this block's share of the shared controllers;
  // the other bits of those words belong to other blocks and read as zero.
  // Block reset release bit; the block starts held in reset.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      blk_release <= BLK_REL_RST;
    end else if (wr_take && i_pstrb[0] && req_idx == IDX_RSTCTL) begin
      blk_release <= i_pwdata[RST_PWM_BIT];
    end
  end

  // Block clock enable bit; the block starts with its clock stopped.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      blk_clk_en <= CLK_EN_RST;
    end else if (wr_take && i_pstrb[0] && req_idx == IDX_CLKCTL) begin
      blk_clk_en <= i_pwdata[CLK_PWM_BIT];
    end
  end

  // A channel is held idle while the block is in reset, while it is
  // stopped, or while its own counter reset is set. Stopping also
  // restarts the period from the top on the next start.
  // The hold is combinational into the sequencer, which registers it, so a
  // stop takes effect one cycle after the write that requests it.
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      hold[c] = !blk_release
             || !control[c][CTL_START]
             || control[c][CTL_CRST];
    end
  end

  // Timing of a channel: the edge that writes the last enabling bit is
  // followed by one idle cycle, then the high phase and the low phase. The
  // pad level is registered once more below, so it lags the sequencer by a
  // cycle. A zero-length phase is skipped, and a channel with both counts
  // at zero stays low. A count that shrinks while a channel runs ends the
  // current phase at the next compare, rather than letting the counter
  // wrap all the way round.
  // One sequencer per channel; the gated clock is modelled as an advance
  // enable so that a stopped clock freezes the phase without a real gate.
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      pulse_phase_counter #(
        .W(CNT_W)
      ) u_seq (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_tick(blk_clk_en),
        .i_hold(hold[g]),
        .i_single(control[g][CTL_SINGLE]),
        .i_high(high_count[g]),
        .i_low(low_count[g]),
        .o_wave(wave[g]),
        .o_phase(phase[g])
      );
    end
  endgenerate

  // Pad level: raw wave, flipped by the invert bit. A held channel's raw
  // wave is low, so an inverted idle channel rests high.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pulse_level <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        o_pulse_level[c] <= wave[c] ^ control[c][CTL_INV];
      end
    end
  end

  // Pad route: enable is active low and follows the route bit; the IO
  // multiplexer outside picks which of its eight pads is used.
  // The pad enable does not depend on the block reset or the clock gate,
  // so a routed pad keeps driving while the block sleeps: its resting level in block reset, its frozen level while the clock is gated.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pulse_oe_n <= '1;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        o_pulse_oe_n[c] <= !control[c][CTL_ROUTE];
      end
    end
  end

  // Software must keep a counter reset set for at least two slow-clock
  // cycles; this logic clears on any edge and does not depend on that.
  // A shorter pulse is harmless here, but software should not rely on it
  // where the counter runs from a genuinely slow clock.

endmodule

// >>> rtl/pulse_pkg.sv
// Shared constants and types for the three-channel low-power pulse generator.
package pulse_pkg;

  // Number of channels and widths of the phase counts, control registers and bus address.
  localparam int NUM_CH = 3;
  localparam int CNT_W = 16;
  localparam int CTL_W = 5;
  localparam int ADDR_W = 12;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [7:0] IDX_HIGH0 = 8'h90;
  localparam logic [7:0] IDX_LOW0 = 8'h92;
  localparam logic [7:0] IDX_HIGH1 = 8'h94;
  localparam logic [7:0] IDX_LOW1 = 8'h96;
  localparam logic [7:0] IDX_HIGH2 = 8'h98;
  localparam logic [7:0] IDX_LOW2 = 8'h9A;
  localparam logic [7:0] IDX_CTRL0 = 8'hA4;
  localparam logic [7:0] IDX_CTRL1 = 8'hA5;
  localparam logic [7:0] IDX_CTRL2 = 8'hA6;
  localparam logic [7:0] IDX_STATUS = 8'hA7;
  localparam logic [7:0] IDX_RSTCTL = 8'h56;
  localparam logic [7:0] IDX_CLKCTL = 8'h57;

  // Field positions of a channel control register.
  localparam int CTL_START = 0;
  localparam int CTL_ROUTE = 1;
  localparam int CTL_SINGLE = 2;
  localparam int CTL_CRST = 3;
  localparam int CTL_INV = 4;

  // Field positions in the shared reset and clock controllers.
  localparam int RST_PWM_BIT = 6;
  localparam int CLK_PWM_BIT = 3;

  // Field positions in the status register.
  localparam int ST_RUN_LSB = 0;
  localparam int ST_DONE_LSB = 3;
  localparam int ST_LVL_LSB = 6;

  // Reset values.
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [CTL_W-1:0] CTRL_RST = 5'h00;
  localparam logic BLK_REL_RST = 1'b0;
  localparam logic CLK_EN_RST = 1'b0;

  // Phase of one channel's waveform.
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_HIGH = 2'b01,
    PH_LOW = 2'b10,
    PH_DONE = 2'b11
  } phase_e;

endpackage

// >>> rtl/pulse_phase_counter.sv
// One channel's phase sequencer: high phase, low phase, repeat or finish.
module pulse_phase_counter
  import pulse_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control.
  input wire logic i_tick,
  input wire logic i_hold,
  input wire logic i_single,
  input wire logic [W-1:0] i_high,
  input wire logic [W-1:0] i_low,
  // State.
  output logic o_wave,
  output phase_e o_phase
);

  // Cycles spent so far in the current phase.
  logic [W-1:0] cnt;
  phase_e phase;

  // Phase that opens a period; an empty high phase is skipped.
  function automatic phase_e first_phase(input logic [W-1:0] h, input logic [W-1:0] l);
    if (h != '0) begin
      first_phase = PH_HIGH;
    end else if (l != '0) begin
      first_phase = PH_LOW;
    end else begin
      first_phase = PH_IDLE;
    end
  endfunction

  // True on the last cycle of a phase of the given length.
  function automatic logic last_cycle(input logic [W-1:0] c, input logic [W-1:0] len);
    last_cycle = ({1'b0, c} + 1'b1) >= {1'b0, len};
  endfunction

  // Sequencer; a held channel rests idle with its counter cleared.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_hold) begin
      phase <= PH_IDLE;
      cnt <= '0;
    end else if (i_tick) begin
      case (phase)
        PH_IDLE: begin
          cnt <= '0;
          phase <= first_phase(i_high, i_low);
        end
        PH_HIGH: begin
          if (last_cycle(cnt, i_high)) begin
            cnt <= '0;
            if (i_low != '0) begin
              phase <= PH_LOW;
            end else if (i_single) begin
              phase <= PH_DONE;
            end else begin
              phase <= first_phase(i_high, i_low);
            end
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        PH_LOW: begin
          if (last_cycle(cnt, i_low)) begin
            cnt <= '0;
            if (i_single) begin
              phase <= PH_DONE;
            end else begin
              phase <= first_phase(i_high, i_low);
            end
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        PH_DONE: begin
          cnt <= '0;
        end
        default: begin
          phase <= PH_IDLE;
          cnt <= '0;
        end
      endcase
    end
  end

  // Raw waveform is high only in the high phase.
  assign o_wave = (phase == PH_HIGH);
  assign o_phase = phase;

endmodule

// >>> sim/low_power_domain_pwm_properties.sv
// Concurrent checks on the pulse generator's register port and pad outputs.
module low_power_domain_pwm_properties
  import pulse_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB side.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Pad side.
  input wire logic [NUM_CH-1:0] o_pulse_level,
  input wire logic [NUM_CH-1:0] o_pulse_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // A write of channel 0 control that the slave accepts at this edge.
  logic ctl0_commit;
  assign ctl0_commit = i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0]
    && i_paddr == 12'h290;

  a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("ready outside access phase");
  a_err_misaligned: assert property (i_psel && !i_penable && i_paddr[1:0] != 2'h0
    |=> o_pslverr && o_prdata == 32'h0)
    else $error("misaligned access not refused");
  a_err_unmapped: assert property (i_psel && !i_penable && i_paddr[11:10] != 2'h0
    |=> o_pslverr)
    else $error("unmapped access not refused");
  a_data_idle_zero: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data not zero while idle");
  a_count_width: assert property (o_pready && !i_pwrite && i_paddr >= 12'h240
    && i_paddr <= 12'h268 |-> o_prdata[31:16] == 16'h0)
    else $error("count wider than sixteen bits");
  a_ctrl_width: assert property (o_pready && !i_pwrite && i_paddr >= 12'h290
    && i_paddr <= 12'h298 |-> o_prdata[31:5] == 27'h0)
    else $error("control wider than five bits");
  a_route_on: assert property (ctl0_commit && i_pwdata[CTL_ROUTE]
    |-> ##2 !o_pulse_oe_n[0])
    else $error("route bit did not enable pad");
  a_oe_quiet: assert property ($changed(o_pulse_oe_n) |-> $past(o_pready && i_pwrite, 2))
    else $error("pad enable moved without a write");
endmodule

bind low_power_domain_pwm low_power_domain_pwm_properties u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_pulse_level(o_pulse_level), .o_pulse_oe_n(o_pulse_oe_n)
);

// >>> sim/pulse_pad_model.sv
// Pad model: shows the channel level while routed, a floating pad otherwise.
module pulse_pad_model
  import pulse_pkg::*;
(
  // Clock.
  input wire logic i_clk,
  // Channel side.
  input wire logic [NUM_CH-1:0] i_level,
  input wire logic [NUM_CH-1:0] i_oe_n,
  // Pad side.
  output logic [NUM_CH-1:0] o_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // An undriven pad has no pull, so it wanders every cycle rather than hold.
  logic [NUM_CH-1:0] float_lvl = '0;
  always @(posedge i_clk) begin
    float_lvl <= ~float_lvl;
  end
  // Driven pads follow the level while the enable is low.
  assign o_pad = (~i_oe_n & i_level) | (i_oe_n & float_lvl);
endmodule

// >>> sim/test_low_power_domain_pwm.sv
// Self-checking bench for the three-channel pulse generator.
module test_low_power_domain_pwm
  import pulse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_CH-1:0] level;
  logic [NUM_CH-1:0] oe_n;
  logic [NUM_CH-1:0] pad;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int samples_checked = 0;
  // Every register, status last; all read zero out of reset.
  logic [11:0] regs [12] = '{12'h240, 12'h248, 12'h250, 12'h258, 12'h260, 12'h268,
    12'h290, 12'h294, 12'h298, 12'h158, 12'h15C, 12'h29C};

  low_power_domain_pwm DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_pulse_level(level), .o_pulse_oe_n(oe_n)
  );
  pulse_pad_model pads (.i_clk(clk), .i_level(level), .i_oe_n(oe_n), .o_pad(pad));

  // Clock at 125 MHz.
  initial begin
    forever #4 clk = ~clk;
  end

  // Compares one value and counts it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("Mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One APB transfer; it starts on a fresh edge so no strobe is set twice in a step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) begin
      err_count++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts one whole high phase and the low phase after it on a pad.
  // In single mode the pad never rises again, so the low count runs to the
  // limit; only there is reaching the limit expected.
  task automatic measure(input int ch, input bit once, output int hi, output int lo);
    int n = 0;
    hi = 0;
    lo = 0;
    while (pad[ch] === 1'b1 && n < 99) begin @(negedge clk); n++; end
    while (pad[ch] !== 1'b1 && n < 99) begin @(negedge clk); n++; end
    while (pad[ch] === 1'b1 && n < 99) begin @(negedge clk); n++; hi++; end
    while (pad[ch] !== 1'b1 && n < 99) begin @(negedge clk); n++; lo++; end
    if (n >= 99 && !once) begin
      err_count++;
      test_done();
    end
  endtask

  // Hang guard.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end

  initial begin
    int hi;
    int lo;
    logic [2:0] frozen;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(oe_n, 32'h7);
    check(level, 32'h0);
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0);
      check(rd, 32'h0);
    end
    // Counts keep sixteen bits, controls five.
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, regs[i], 32'hFFFFFFFF);
      apb(1'b0, regs[i], 32'h0);
      check(rd, (i < 6) ? 32'h0000FFFF : 32'h0000001F);
      apb(1'b1, regs[i], 32'h0);
    end
    apb(1'b0, 12'h244, 32'h0);
    check(er, 32'h1);
    apb(1'b1, 12'h240, 32'h5A5A);
    apb(1'b0, 12'h242, 32'h0);
    check(er, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, 12'h242, 32'h5);
    check(er, 32'h1);
    apb(1'b0, 12'h240, 32'h0);
    check(rd, 32'h00005A5A);
    // Release and clock the block, then run every channel with its own shape.
    apb(1'b1, 12'h158, 32'h40);
    apb(1'b1, 12'h15C, 32'h08);
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, 12'h240 + 12'(c * 16), 32'(c + 3));
      apb(1'b1, 12'h248 + 12'(c * 16), 32'(c + 2));
      apb(1'b1, 12'h290 + 12'(c * 4), 32'h03);
    end
    repeat (2) @(negedge clk);
    check(oe_n, 32'h0);
    for (int c = 0; c < 3; c++) begin
      measure(c, 1'b0, hi, lo);
      check(hi, 32'(c + 3));
      check(lo, 32'(c + 2));
    end
    // Stopped with invert: rests at the inverted idle level.
    apb(1'b1, 12'h290, 32'h12);
    repeat (10) @(negedge clk);
    check(level[0], 32'h1);
    apb(1'b1, 12'h290, 32'h13);
    measure(0, 1'b0, hi, lo);
    check(hi, 32'h2);
    check(lo, 32'h3);
    // Counter reset holds the output low, longer than two slow cycles.
    apb(1'b1, 12'h290, 32'h0B);
    repeat (10) @(negedge clk);
    check(level[0], 32'h0);
    apb(1'b1, 12'h290, 32'h03);
    measure(0, 1'b0, hi, lo);
    check(hi, 32'h3);
    // Single period on channel 1 after a fresh enable.
    // Stopping with the route bit kept leaves the pad driven low.
    apb(1'b1, 12'h294, 32'h02);
    apb(1'b1, 12'h294, 32'h07);
    measure(1, 1'b1, hi, lo);
    check(hi, 32'h4);
    check(level[1], 32'h0);
    apb(1'b0, 12'h29C, 32'h0);
    check(rd[4], 32'h1);
    // A gated clock freezes every level.
    apb(1'b1, 12'h15C, 32'h00);
    repeat (2) @(negedge clk);
    frozen = level;
    repeat (8) @(negedge clk);
    check(level, frozen);
    apb(1'b1, 12'h15C, 32'h08);
    apb(1'b1, 12'h158, 32'h00);
    repeat (3) @(negedge clk);
    check(level, 32'h0);
    apb(1'b1, 12'h290, 32'h01);
    repeat (2) @(negedge clk);
    check(oe_n[0], 32'h1);
    test_done();
  end
endmodule
